// ==== inc/ess_pkg.sv ====
/*
 * Shared constants for the EEPROM store sequencer: scratch-pad layout,
 * reset values, control and status registers, instruction codes, states.
 * Assumes a byte-wide register port with 16-bit addresses.
 */
package ess_pkg;
  // scratch-pad entries
  localparam logic [15:0] REF_B_STORE_COUNT_OFS = 16'h0e1f;
  localparam logic [15:0] REF_B_STORE_START_OFS = 16'h0e20;
  localparam logic [15:0] REF_C_STORE_COUNT_OFS = 16'h0e22;
  localparam logic [15:0] REF_C_STORE_START_OFS = 16'h0e23;
  localparam logic [15:0] REF_D_STORE_COUNT_OFS = 16'h0e25;
  localparam logic [15:0] REF_D_STORE_START_OFS = 16'h0e26;
  localparam logic [15:0] LOOP0_GENERAL_STORE_COUNT_OFS = 16'h0e28;
  localparam logic [15:0] LOOP0_GENERAL_STORE_START_OFS = 16'h0e29;
  localparam logic [7:0] REF_B_STORE_COUNT_RST = 8'h1e;
  localparam logic [15:0] REF_B_STORE_START_RST = 16'h0320;
  localparam logic [7:0] REF_C_STORE_COUNT_RST = 8'h1e;
  localparam logic [15:0] REF_C_STORE_START_RST = 16'h0340;
  localparam logic [7:0] REF_D_STORE_COUNT_RST = 8'h1e;
  localparam logic [15:0] REF_D_STORE_START_RST = 16'h0360;
  localparam logic [7:0] LOOP0_GENERAL_STORE_COUNT_RST = 8'h1e;
  localparam logic [15:0] LOOP0_GENERAL_STORE_START_RST = 16'h0400;
  localparam int SEQ_LEN = 12;
  localparam logic [15:0] SEQ_BASE = REF_B_STORE_COUNT_OFS;
  localparam logic [15:0] SEQ_END = 16'h0e2b;
  localparam logic [3:0] CKSUM_IDX = 4'(LOOP0_GENERAL_STORE_COUNT_OFS - SEQ_BASE);
  localparam logic [7:0] SEQ_RST [SEQ_LEN] = '{
    REF_B_STORE_COUNT_RST, REF_B_STORE_START_RST[15:8], REF_B_STORE_START_RST[7:0],
    REF_C_STORE_COUNT_RST, REF_C_STORE_START_RST[15:8], REF_C_STORE_START_RST[7:0],
    REF_D_STORE_COUNT_RST, REF_D_STORE_START_RST[15:8], REF_D_STORE_START_RST[7:0],
    LOOP0_GENERAL_STORE_COUNT_RST, LOOP0_GENERAL_STORE_START_RST[15:8],
    LOOP0_GENERAL_STORE_START_RST[7:0]};
  // control and status
  localparam logic [15:0] CTRL_OFS = 16'h0e3c;
  localparam logic [15:0] STATUS_OFS = 16'h0e3d;
  localparam logic [15:0] PTR_LO_OFS = 16'h0e3e;
  localparam logic [15:0] PTR_HI_OFS = 16'h0e3f;
  localparam int CTRL_START_BIT = 0;
  // instruction codes
  localparam logic [7:0] INS_UPDATE = 8'h80;
  localparam logic [7:0] INS_CALIB = 8'h91;
  localparam int INS_CMD_BIT = 7;
  // output buffer
  localparam int FIFO_WIDTH = 24;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [3:0] {
    ESS_IDLE = 4'h0, ESS_FETCH = 4'h1, ESS_PUT_INS = 4'h3, ESS_PUT_AHI = 4'h2,
    ESS_PUT_ALO = 4'h6, ESS_ISSUE = 4'h7, ESS_WAIT = 4'h5, ESS_CAP = 4'h4,
    ESS_PUT_DAT = 4'hc, ESS_PUT_CK = 4'hd
  } ess_state_e;
endpackage

// ==== inc/ess_fifo_if.sv ====
/*
 * Byte-stream carrier between the sequencer and its output FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface ess_fifo_if #(parameter int W = 24);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
  modport store (input in_valid, input in_data, input out_ready,
                 output in_ready, output out_valid, output out_data);
endinterface // ess_fifo_if

// ==== hdl/ess_fifo.sv ====
/*
 * Small FIFO with a registered output stage, valid/ready on both sides.
 * Assumes DEPTH is a power of two and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module ess_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  ess_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] count;
  wire push = f.in_valid && f.in_ready;
  // refill output stage when empty or being taken
  wire load = (count != '0) && (!f.out_valid || f.out_ready);

  // back-pressure: refuse when storage full
  assign f.in_ready = count != (AW+1)'(DEPTH);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= f.in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      f.out_valid <= 1'b0;
      f.out_data <= '0;
    end else begin
      if (push) begin
        wp <= wp + AW'(1);
      end
      if (load) begin
        f.out_data <= mem[rp];
        rp <= rp + AW'(1);
        f.out_valid <= 1'b1;
      end else if (f.out_ready) begin
        f.out_valid <= 1'b0;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule // ess_fifo

// ==== hdl/ess_store_seq.sv ====
/*
 * EEPROM store sequencer: walks the store scratch-pad, emits instruction,
 * address and copied register bytes with their EEPROM address.
 * Assumes a register map read port answering one cycle after map_rd,
 * and an EEPROM writer draining ee_* with valid/ready.
 */
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
module ess_store_seq
  import ess_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rd_data,
  output logic map_rd,
  output logic [15:0] map_addr,
  input wire logic [7:0] map_rdata,
  output logic ee_valid,
  output logic [15:0] ee_addr,
  output logic [7:0] ee_data,
  input wire logic ee_ready
);
  ess_state_e state;
  ess_state_e next_state;
  logic [7:0] seq [SEQ_LEN];
  logic [3:0] idx;
  logic [7:0] ins;
  logic [15:0] start_q;
  logic [15:0] src;
  logic [15:0] ptr;
  logic [7:0] cnt;
  logic [7:0] byte_q;
  logic [7:0] csum;
  logic done;

  ess_fifo_if #(.W(FIFO_WIDTH)) fio ();

  ess_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .f(fio.store)
  );

  // register decode
  wire busy = state != ESS_IDLE;
  wire in_seq = (addr >= SEQ_BASE) && (addr < SEQ_END);
  wire [3:0] widx = 4'(addr - SEQ_BASE);
  // scratch-pad is frozen while a run walks it
  wire seq_wr = wr && in_seq && !busy;
  wire start = wr && (addr == CTRL_OFS) && wr_data[CTRL_START_BIT] && !busy;
  wire [7:0] rd_mux = in_seq ? seq[widx] :
                      (addr == STATUS_OFS) ? {6'h00, done, busy} :
                      (addr == PTR_LO_OFS) ? ptr[7:0] :
                      (addr == PTR_HI_OFS) ? ptr[15:8] : 8'h00;

  // sequence walk
  wire [4:0] idx1 = {1'b0, idx} + 5'h01;
  wire [4:0] idx2 = {1'b0, idx} + 5'h02;
  wire [7:0] seq_a1 = (idx1 < 5'(SEQ_LEN)) ? seq[idx1[3:0]] : 8'h00;
  wire [7:0] seq_a2 = (idx2 < 5'(SEQ_LEN)) ? seq[idx2[3:0]] : 8'h00;
  // anything with the top bit set is a one-byte command
  wire is_data = !ins[INS_CMD_BIT];
  wire [4:0] idx_next = is_data ? idx2 + 5'h01 : idx1;
  wire last = idx_next >= 5'(SEQ_LEN);
  wire put_st = (state == ESS_PUT_INS) || (state == ESS_PUT_AHI) || (state == ESS_PUT_ALO) ||
                (state == ESS_PUT_DAT) || (state == ESS_PUT_CK);
  // two's complement makes the whole image sum to zero
  wire [7:0] ck_byte = 8'h00 - csum;
  wire [7:0] push_byte = (state == ESS_PUT_INS) ? ins :
                         (state == ESS_PUT_AHI) ? start_q[15:8] :
                         (state == ESS_PUT_ALO) ? start_q[7:0] :
                         (state == ESS_PUT_CK) ? ck_byte : byte_q;
  wire accept = put_st && fio.in_ready;
  wire copy_end = (state == ESS_PUT_DAT) && (cnt == 8'h00);
  wire end_entry = accept && (((state == ESS_PUT_INS) && !is_data) || (state == ESS_PUT_CK) ||
                              (copy_end && (idx != CKSUM_IDX)));

  assign fio.in_valid = put_st;
  assign fio.in_data = {ptr, push_byte};
  assign fio.out_ready = ee_ready;
  assign ee_valid = fio.out_valid;
  assign ee_addr = fio.out_data[23:8];
  assign ee_data = fio.out_data[7:0];

  always_comb begin
    next_state = state;
    unique case (state)
      ESS_IDLE: begin
        if (start) begin
          next_state = ESS_FETCH;
        end
      end
      ESS_FETCH: next_state = ESS_PUT_INS;
      ESS_PUT_INS: begin
        if (accept) begin
          next_state = is_data ? ESS_PUT_AHI : (last ? ESS_IDLE : ESS_FETCH);
        end
      end
      ESS_PUT_AHI: begin
        if (accept) begin
          next_state = ESS_PUT_ALO;
        end
      end
      ESS_PUT_ALO: begin
        if (accept) begin
          next_state = ESS_ISSUE;
        end
      end
      ESS_ISSUE: next_state = ESS_WAIT;
      ESS_WAIT: next_state = ESS_CAP;
      ESS_CAP: next_state = ESS_PUT_DAT;
      ESS_PUT_DAT: begin
        if (accept) begin
          if (cnt != 8'h00) begin
            next_state = ESS_ISSUE;
          end else if (idx == CKSUM_IDX) begin
            next_state = ESS_PUT_CK;
          end else begin
            next_state = last ? ESS_IDLE : ESS_FETCH;
          end
        end
      end
      ESS_PUT_CK: begin
        if (accept) begin
          next_state = last ? ESS_IDLE : ESS_FETCH;
        end
      end
      default: next_state = ESS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ESS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < SEQ_LEN; i++) begin
        seq[i] <= SEQ_RST[i];
      end
    end else if (seq_wr) begin
      seq[widx] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      done <= 1'b0;
    end else begin
      rd_data <= rd ? rd_mux : 8'h00;
      if (start) begin
        done <= 1'b0;
      end else if (end_entry && last) begin
        done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idx <= 4'h0;
      ins <= 8'h00;
      start_q <= 16'h0000;
    end else if (start) begin
      idx <= 4'h0;
    end else if (state == ESS_FETCH) begin
      ins <= seq[idx];
      start_q <= {seq_a1, seq_a2};
    end else if (end_entry) begin
      idx <= idx_next[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr <= 16'h0000;
      csum <= 8'h00;
    end else if (start) begin
      ptr <= 16'h0000;
      csum <= 8'h00;
    end else if (accept) begin
      ptr <= ptr + 16'h0001;
      csum <= csum + push_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 8'h00;
      src <= 16'h0000;
      byte_q <= 8'h00;
      map_rd <= 1'b0;
      map_addr <= 16'h0000;
    end else begin
      map_rd <= state == ESS_ISSUE;
      if (state == ESS_ISSUE) begin
        map_addr <= src;
      end
      if ((state == ESS_PUT_ALO) && accept) begin
        cnt <= ins;
        src <= start_q;
      end else if ((state == ESS_PUT_DAT) && accept && (cnt != 8'h00)) begin
        cnt <= cnt - 8'h01;
        src <= src + 16'h0001;
      end
      if (state == ESS_CAP) begin
        byte_q <= map_rdata;
      end
    end
  end

  property p_count_load;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_ALO && accept) |=> (cnt == $past(ins)) && (src == $past(start_q));
  endproperty
  a_count_load: assert property (p_count_load) else $error("count or source not loaded");

  property p_ins_first;
    @(posedge clk) disable iff (rst)
    (state == ESS_FETCH) |=> (state == ESS_PUT_INS) && fio.in_valid && (push_byte == ins)
      && (fio.in_data[23:8] == ptr);
  endproperty
  a_ins_first: assert property (p_ins_first) else $error("instruction byte not pushed first");

  property p_addr_bytes;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_AHI && accept) |=> (state == ESS_PUT_ALO) && (push_byte == start_q[7:0])
      && (ptr == $past(ptr) + 16'h0001);
  endproperty
  a_addr_bytes: assert property (p_addr_bytes) else $error("address bytes out of order");

  property p_map_read;
    @(posedge clk) disable iff (rst)
    (state == ESS_ISSUE) |=> map_rd && (map_addr == $past(src)) ##2 (state == ESS_PUT_DAT)
      && (byte_q == $past(map_rdata));
  endproperty
  a_map_read: assert property (p_map_read) else $error("register byte copy wrong");

  property p_defaults;
    @(posedge clk)
    $past(rst) |-> (seq[0] == 8'h1e) && ({seq[1], seq[2]} == 16'h0320) && (seq[3] == 8'h1e)
      && ({seq[4], seq[5]} == 16'h0340) && (seq[6] == 8'h1e) && ({seq[7], seq[8]} == 16'h0360)
      && (seq[9] == 8'h1e) && ({seq[10], seq[11]} == 16'h0400);
  endproperty
  a_defaults: assert property (p_defaults) else $error("scratch-pad defaults wrong");

  property p_cksum;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_CK && accept) |=> (csum == 8'h00) && (idx == CKSUM_IDX + 4'h3);
  endproperty
  a_cksum: assert property (p_cksum) else $error("checksum does not close image");

  property p_update;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_INS && accept && ins == INS_UPDATE) |=> (state inside {ESS_FETCH, ESS_IDLE})
      && (ptr == $past(ptr) + 16'h0001) ##1 !map_rd;
  endproperty
  a_update: assert property (p_update) else $error("update command copied data");

  property p_calib;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_INS && accept && ins == INS_CALIB) |=> (state inside {ESS_FETCH, ESS_IDLE})
      && (ptr == $past(ptr) + 16'h0001);
  endproperty
  a_calib: assert property (p_calib) else $error("calibration command mishandled");

  property p_ascend;
    @(posedge clk) disable iff (rst)
    ($changed(idx) && $past(state) != ESS_IDLE) |-> (idx > $past(idx)) && (state inside {ESS_FETCH, ESS_IDLE});
  endproperty
  a_ascend: assert property (p_ascend) else $error("entry walk not ascending");

  logic [7:0] copied;
  always_ff @(posedge clk) begin
    if (rst) begin
      copied <= 8'h00;
    end else if ((state == ESS_PUT_ALO) && accept) begin
      copied <= 8'h00;
    end else if ((state == ESS_PUT_DAT) && accept) begin
      copied <= copied + 8'h01;
    end
  end

  property p_copy_len;
    @(posedge clk) disable iff (rst)
    (copy_end && accept) |-> (copied == ins);
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length differs from instruction");

  property p_ptr_step;
    @(posedge clk) disable iff (rst)
    accept |=> (ptr == $past(ptr) + 16'h0001);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not advanced by one");

  property p_stall_hold;
    @(posedge clk) disable iff (rst)
    (put_st && !fio.in_ready) |=> $stable(state) && $stable(push_byte) && $stable(ptr);
  endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("byte changed while fifo full");

  property p_ck_loop;
    @(posedge clk) disable iff (rst)
    (state == ESS_PUT_CK) |-> (idx == CKSUM_IDX) && is_data;
  endproperty
  a_ck_loop: assert property (p_ck_loop) else $error("checksum outside loop entry");

  property p_frozen;
    @(posedge clk) disable iff (rst)
    (busy && wr && in_seq) |=> (seq[$past(widx)] == $past(seq[widx]));
  endproperty
  a_frozen: assert property (p_frozen) else $error("scratch-pad changed during run");

  c_run_done: cover property (@(posedge clk) disable iff (rst) $fell(busy) && done);
  c_cksum: cover property (@(posedge clk) disable iff (rst) state == ESS_PUT_CK && accept);
  c_stall: cover property (@(posedge clk) disable iff (rst) put_st && !fio.in_ready);
  c_calib: cover property (@(posedge clk) disable iff (rst) state == ESS_PUT_INS && ins == INS_CALIB);
  c_update: cover property (@(posedge clk) disable iff (rst) state == ESS_PUT_INS && ins == INS_UPDATE && accept);
endmodule // ess_store_seq

// ==== tb/ess_far_model.sv ====
/*
 * Far-side model of the store sequencer: register map read port and the
 * EEPROM byte sink, which logs every byte taken with its location.
 * Assumes one clock; clear empties the log before each run.
 */
`timescale 1ns/100ps
module ess_far_model (
  input wire logic clk,
  input wire logic clear,
  input wire logic slow,
  input wire logic map_rd,
  input wire logic [15:0] map_addr,
  output logic [7:0] map_rdata,
  input wire logic ee_valid,
  input wire logic [15:0] ee_addr,
  input wire logic [7:0] ee_data,
  output logic ee_ready
);
  logic [7:0] mem [256];
  logic [15:0] loc [256];
  int count;
  logic [2:0] tick;
  initial begin
    count = 0;
    tick = 3'h0;
    map_rdata = 8'h00;
  end
  // slow sink takes one byte in eight cycles, so the fifo backs up
  assign ee_ready = !slow || (tick == 3'h0);
  always @(posedge clk) begin
    tick <= tick + 3'h1;
    // data outside the answer cycle are scrambled on purpose
    map_rdata <= map_rd ? (map_addr[7:0] ^ map_addr[15:8] ^ 8'h5a) : ~map_rdata;
    if (clear) begin
      count <= 0;
    end else if (ee_valid && ee_ready) begin
      mem[count[7:0]] <= ee_data;
      loc[count[7:0]] <= ee_addr;
      count <= count + 1;
    end
  end
endmodule // ess_far_model

// ==== tb/test_eeprom_store_sequencer.sv ====
/*
 * Self-checking bench of the store sequencer: register tasks, three runs
 * with expected images built from the scratch-pad contents.
 * Assumes ess_pkg constants and the far-side model.
 */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_eeprom_store_sequencer import ess_pkg::*;;
  logic clk, rst, wr, rd, slow, clear, map_rd, ee_valid, ee_ready;
  logic [15:0] addr, map_addr, ee_addr;
  logic [7:0] wr_data, rd_data, map_rdata, ee_data, d;
  logic [7:0] seq [SEQ_LEN];
  logic [7:0] exp_b [256];
  int exp_n, bad_count, cmp_count;

  ess_store_seq ess_store_seq_i (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr(wr),
    .rd(rd), .rd_data(rd_data), .map_rd(map_rd), .map_addr(map_addr), .map_rdata(map_rdata),
    .ee_valid(ee_valid), .ee_addr(ee_addr), .ee_data(ee_data), .ee_ready(ee_ready));
  ess_far_model ess_far_model_i (.clk(clk), .clear(clear), .slow(slow), .map_rd(map_rd),
    .map_addr(map_addr), .map_rdata(map_rdata), .ee_valid(ee_valid), .ee_addr(ee_addr),
    .ee_data(ee_data), .ee_ready(ee_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rd_data;
  endtask

  task automatic push(input logic [7:0] v);
    exp_b[exp_n] = v;
    exp_n++;
  endtask

  // walks the scratch-pad the way the sequencer must
  task automatic build();
    int i;
    logic [15:0] b;
    logic [7:0] sum;
    exp_n = 0;
    i = 0;
    sum = 8'h00;
    while (i < SEQ_LEN) begin
      push(seq[i]);
      if (seq[i][INS_CMD_BIT]) begin
        i++;
      end else begin
        push(seq[i+1]);
        push(seq[i+2]);
        for (int k = 0; k <= int'(seq[i]); k++) begin
          b = {seq[i+1], seq[i+2]} + 16'(k);
          push(b[7:0] ^ b[15:8] ^ 8'h5a);
        end
        if (i == int'(CKSUM_IDX)) begin
          for (int k = 0; k < exp_n; k++) sum = sum + exp_b[k];
          push(8'h00 - sum);
        end
        i += 3;
      end
    end
  endtask

  task automatic run_check(input string nm);
    int n;
    build();
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    wr_reg(CTRL_OFS, 8'h01);
    rd_reg(STATUS_OFS, d);
    `CHK("busy", 8'h01, d)
    // scratch writes while busy must be dropped
    wr_reg(SEQ_BASE, 8'h55);
    n = 0;
    do begin
      rd_reg(STATUS_OFS, d);
      n++;
    end while (!d[1] && n < 1500);
    n = 0;
    while (ess_far_model_i.count != exp_n && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK("status", 8'h02, d)
    `CHK("byte count", exp_n, ess_far_model_i.count)
    for (int k = 0; k < exp_n; k++) begin
      `CHK("image byte", exp_b[k], ess_far_model_i.mem[k])
      `CHK("image location", 16'(k), ess_far_model_i.loc[k])
    end
    rd_reg(PTR_LO_OFS, d);
    `CHK("pointer low", 8'(exp_n), d)
    rd_reg(PTR_HI_OFS, d);
    `CHK("pointer high", 8'(exp_n >> 8), d)
    for (int k = 0; k < SEQ_LEN; k++) begin
      rd_reg(SEQ_BASE + 16'(k), d);
      `CHK("scratch kept", seq[k], d)
    end
    $display("test %s finished", nm);
  endtask

  initial begin
    #(8 * 40000);
    bad_count++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wr_data = 8'h00;
    slow = 1'b0;
    clear = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < SEQ_LEN; k++) begin
      rd_reg(SEQ_BASE + 16'(k), d);
      `CHK("scratch default", SEQ_RST[k], d)
      seq[k] = SEQ_RST[k];
    end
    rd_reg(16'h0e00, d);
    `CHK("unmapped read", 8'h00, d)
    rd_reg(STATUS_OFS, d);
    `CHK("status after reset", 8'h00, d)
    $display("test defaults finished");
    run_check("default image");
    // one-byte copy, then update, calibrate, update
    seq[0] = 8'h00;
    seq[1] = 8'h05;
    seq[2] = 8'h10;
    seq[3] = INS_UPDATE;
    seq[4] = INS_CALIB;
    seq[5] = INS_UPDATE;
    for (int k = 0; k < 6; k++) wr_reg(SEQ_BASE + 16'(k), seq[k]);
    slow <= 1'b1;
    run_check("commands with slow sink");
    // largest count that is still a data instruction
    seq[0] = 8'h7f;
    seq[1] = 8'h01;
    seq[2] = 8'hf0;
    for (int k = 0; k < 3; k++) wr_reg(SEQ_BASE + 16'(k), seq[k]);
    slow <= 1'b0;
    run_check("long copy");
    finish_test();
  end
endmodule // test_eeprom_store_sequencer
